// file: csr_port_map.vh
// Register map, field positions, reset values and timing counts of the CSR port block
// How it works
// - Data port writes and reads the register chosen by the select port.
// - Priority demand bit starts priority block service, device clears it when done.
// - Stopped flag read-only, set by reset or stop; holds core in reset.
// - Transmit disable lets current frame finish, then stops all transmit ring access.
// - Receive disable lets current frame finish, then refuses frames; local busy from the moment it is set, outside the stopped phase.
// - Transmitter-on sets at start with disable clear, or when disable clears later.
// - Transmitter-on clears on disable recognised, stop, or reset; writes ignored.
// - Receiver-on sets at start with disable clear, or when disable clears later.
// - Receiver-on clears on disable recognised, stop, or reset; writes ignored.
// - Interrupt pin low only when interrupt enable and interrupt flag both set.
// - Interrupt enable read/write, cleared by stop or reset, not settable while stopped.
// - Interrupt flag is OR of the five event bits, cleared with them.
// - Memory error sets when ready misses 256 cycles after address as master.
// - Memory error releases bus, turns off receiver and transmitter, interrupts.
// - Error bits set by device only, write one clears, stop or reset clears.
// - Missed frame bit sets when a channel drops a frame, then interrupts.
// - Address of missed frame reported on a status request.
// - Select bits 3 to 1 choose the register; reset clears the select port.
// - Transmit interrupt bit sets on transmit ring update, write one clears.
`ifndef CSR_PORT_MAP_VH
`define CSR_PORT_MAP_VH

// Select port fields
`define SEL_BYTE_MODE_BIT 7
`define SEL_INDEX_HI 3
`define SEL_INDEX_LO 1
`define SEL_HIGH_BYTE_BIT 0
`define SEL_RESET 8'h00

// Register indices reached through the data port
`define IDX_MAIN_CONTROL_STATUS 3'h0
`define IDX_LAST_EXT 3'h5

// Main control/status field positions
`define MCS_PRIORITY_TX_DEMAND 15
`define MCS_STOPPED 14
`define MCS_TX_DISABLE 13
`define MCS_RX_DISABLE 12
`define MCS_TX_ACTIVE 11
`define MCS_RX_ACTIVE 10
`define MCS_IRQ_ENABLE 9
`define MCS_IRQ_FLAG 8
`define MCS_MEM_TIMEOUT_ERR 7
`define MCS_MISSED_FRAME 6
`define MCS_PRIMITIVE_IRQ 3
`define MCS_TX_IRQ 2
`define MCS_RX_IRQ 1

// Sticky event vector order: missed, mem err, primitive, tx, rx
`define EVT_MISSED 4
`define EVT_MEM_ERR 3
`define EVT_PRIM 2
`define EVT_TX 1
`define EVT_RX 0
`define EVT_COUNT 5

// Bus master ready timeout in system clock cycles
`define MEM_TIMEOUT_CYC 256

`endif

// file: sticky_event_flags.v
// Bank of sticky event flags with write-one-to-clear and set priority
module sticky_event_flags #(
  parameter WIDTH = 5
) (
  // Clock and reset
  input wire i_ref_clk,
  input wire i_rst,
  // Events and clears
  input wire [WIDTH-1:0] i_set,
  input wire [WIDTH-1:0] i_clr,
  // Flags
  output wire [WIDTH-1:0] o_flag
);

  reg [WIDTH-1:0] flag;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1)
    begin : g_flag
      always @(posedge i_ref_clk or posedge i_rst)
      begin
        if (i_rst)
          flag[g] <= 1'b0;
        else if (i_set[g])
          flag[g] <= 1'b1; // Set wins over a clear in the same cycle
        else if (i_clr[g])
          flag[g] <= 1'b0;
      end
    end
  endgenerate

  assign o_flag = flag;

endmodule // sticky_event_flags

// file: ready_watchdog.v
// Counts cycles a master access waits for ready and flags a timeout
module ready_watchdog #(
  parameter LIMIT = 256,
  parameter CW = 9
) (
  // Clock and reset
  input wire i_ref_clk,
  input wire i_rst,
  // Access status
  input wire i_waiting,
  // Timeout event
  output reg o_timeout
);

  reg [CW-1:0] count;
  reg fired;

  always @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      count <= {CW{1'b0}};
      fired <= 1'b0;
      o_timeout <= 1'b0;
    end
    else if (!i_waiting)
    begin
      count <= {CW{1'b0}};
      fired <= 1'b0;
      o_timeout <= 1'b0;
    end
    else
    begin
      // One pulse per stalled access
      if (count == LIMIT[CW-1:0] - 1'b1 && !fired)
      begin
        o_timeout <= 1'b1;
        fired <= 1'b1;
      end
      else
        o_timeout <= 1'b0;
      if (!fired)
        count <= count + 1'b1;
    end
  end

endmodule // ready_watchdog

// file: csr_data_port_and_master_control.v
// Host register ports and the main control/status register logic
`include "csr_port_map.vh"

module csr_data_port_and_master_control #(
  parameter ADDR_W = 24
) (
  // Clock and reset
  input wire i_ref_clk,
  input wire i_rst,
  // Host slave port
  input wire i_sel,
  input wire i_port_is_select,
  input wire i_wr,
  input wire i_rd,
  input wire [15:0] i_wdata,
  output reg [15:0] o_rdata,
  output reg o_rvalid,
  // Other control registers
  output reg [2:0] o_ext_index,
  output reg o_ext_wr,
  output reg [15:0] o_ext_wdata,
  input wire [15:0] i_ext_rdata,
  output reg o_byte_mode,
  output reg o_high_byte,
  // Primitive and core events
  input wire i_start_prim,
  input wire i_stop_prim,
  input wire i_tx_frame_busy,
  input wire i_rx_frame_busy,
  input wire i_prio_done,
  input wire i_rx_ring_update,
  input wire i_tx_ring_update,
  input wire i_prim_update,
  input wire i_rx_drop,
  input wire [ADDR_W-1:0] i_drop_addr,
  input wire i_status_req,
  // Bus master status
  input wire i_bus_master,
  input wire i_addr_driven,
  input wire i_ready,
  // Control outputs
  output reg o_stopped,
  output reg o_tx_ring_enable,
  output reg o_rx_ring_enable,
  output reg o_local_busy,
  output reg o_prio_service,
  output reg o_bus_release,
  output reg [ADDR_W-1:0] o_status_addr,
  output reg o_status_valid,
  output reg o_irq_flag_n
);

  // ****************************************
  // Host access decode
  // ****************************************
  wire access_wr;
  wire access_rd;
  wire sel_wr;
  wire data_wr;
  wire mcs_wr;
  wire ext_hit;
  reg [7:0] select_port;
  wire [2:0] index;

  assign access_wr = i_sel & i_wr;
  assign access_rd = i_sel & i_rd;
  assign sel_wr = access_wr & i_port_is_select;
  assign data_wr = access_wr & ~i_port_is_select;
  assign index = select_port[`SEL_INDEX_HI:`SEL_INDEX_LO];
  assign mcs_wr = data_wr & (index == `IDX_MAIN_CONTROL_STATUS);
  assign ext_hit = (index != `IDX_MAIN_CONTROL_STATUS) && (index <= `IDX_LAST_EXT);

  always @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      select_port <= `SEL_RESET;
    else if (sel_wr)
      select_port <= {i_wdata[7], 3'b000, i_wdata[3:0]};
  end

  // ****************************************
  // Control state
  // ****************************************
  reg stopped;
  reg tx_disable;
  reg rx_disable;
  reg tx_active;
  reg rx_active;
  reg irq_enable;
  reg prio_demand;
  reg prio_rearm;
  reg [ADDR_W-1:0] drop_addr;
  wire [`EVT_COUNT-1:0] evt_set;
  wire [`EVT_COUNT-1:0] evt_clr;
  wire [`EVT_COUNT-1:0] evt_flag;
  wire irq_flag;
  wire mem_timeout;
  wire tx_disable_seen;
  wire rx_disable_seen;
  wire prio_write;

  // Core events only count outside the stopped phase; primitive update counts at any time
  assign evt_set[`EVT_MISSED] = i_rx_drop & ~stopped;
  assign evt_set[`EVT_MEM_ERR] = mem_timeout & ~stopped;
  assign evt_set[`EVT_PRIM] = i_prim_update;
  assign evt_set[`EVT_TX] = i_tx_ring_update & ~stopped;
  assign evt_set[`EVT_RX] = i_rx_ring_update & ~stopped;

  // Write one clears, stop clears all
  assign evt_clr[`EVT_MISSED] = (mcs_wr & i_wdata[`MCS_MISSED_FRAME]) | i_stop_prim;
  assign evt_clr[`EVT_MEM_ERR] = (mcs_wr & i_wdata[`MCS_MEM_TIMEOUT_ERR]) | i_stop_prim;
  assign evt_clr[`EVT_PRIM] = (mcs_wr & i_wdata[`MCS_PRIMITIVE_IRQ]) | i_stop_prim;
  assign evt_clr[`EVT_TX] = (mcs_wr & i_wdata[`MCS_TX_IRQ]) | i_stop_prim;
  assign evt_clr[`EVT_RX] = (mcs_wr & i_wdata[`MCS_RX_IRQ]) | i_stop_prim;

  sticky_event_flags #(
    .WIDTH(`EVT_COUNT)
  ) u_flags (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_set(evt_set),
    .i_clr(evt_clr),
    .o_flag(evt_flag)
  );

  assign irq_flag = |evt_flag;

  ready_watchdog #(
    .LIMIT(`MEM_TIMEOUT_CYC),
    .CW(9)
  ) u_watchdog (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_waiting(i_bus_master & i_addr_driven & ~i_ready),
    .o_timeout(mem_timeout)
  );

  // Disable recognised once any frame in progress is finished
  assign tx_disable_seen = tx_disable & ~i_tx_frame_busy;
  assign rx_disable_seen = rx_disable & ~i_rx_frame_busy;
  assign prio_write = mcs_wr & i_wdata[`MCS_PRIORITY_TX_DEMAND];

  // ****************************************
  // Transmitter and receiver on
  // ****************************************
  reg next_tx_active;
  reg next_rx_active;
  wire tx_enable_write;
  wire rx_enable_write;

  // Host clearing a set disable bit while running
  assign tx_enable_write = ~stopped & mcs_wr & tx_disable & ~i_wdata[`MCS_TX_DISABLE];
  assign rx_enable_write = ~stopped & mcs_wr & rx_disable & ~i_wdata[`MCS_RX_DISABLE];

  always @*
  begin
    next_tx_active = tx_active;
    if (i_stop_prim || mem_timeout)
      next_tx_active = 1'b0;
    else if (tx_enable_write)
      next_tx_active = 1'b1;
    else if (tx_disable_seen)
      next_tx_active = 1'b0;
    else if (i_start_prim && !tx_disable)
      next_tx_active = 1'b1;
  end

  always @*
  begin
    next_rx_active = rx_active;
    if (i_stop_prim || mem_timeout)
      next_rx_active = 1'b0;
    else if (rx_enable_write)
      next_rx_active = 1'b1;
    else if (rx_disable_seen)
      next_rx_active = 1'b0;
    else if (i_start_prim && !rx_disable)
      next_rx_active = 1'b1;
  end

  always @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      stopped <= 1'b1;
      tx_disable <= 1'b0;
      rx_disable <= 1'b0;
      tx_active <= 1'b0;
      rx_active <= 1'b0;
      irq_enable <= 1'b0;
      prio_demand <= 1'b0;
      prio_rearm <= 1'b0;
    end
    else
    begin
      if (mcs_wr)
      begin
        tx_disable <= i_wdata[`MCS_TX_DISABLE];
        rx_disable <= i_wdata[`MCS_RX_DISABLE];
      end

      // Stopped phase
      if (i_stop_prim)
        stopped <= 1'b1;
      else if (i_start_prim)
        stopped <= 1'b0;

      // Ring access acknowledge bits
      tx_active <= next_tx_active;
      rx_active <= next_rx_active;

      // Interrupt enable
      if (i_stop_prim)
        irq_enable <= 1'b0;
      else if (mcs_wr)
      begin
        if (!i_wdata[`MCS_IRQ_ENABLE])
          irq_enable <= 1'b0;
        else if (!stopped)
          irq_enable <= 1'b1;
      end

      // Priority demand with re-arm during service
      if (stopped || i_stop_prim)
      begin
        prio_demand <= 1'b0;
        prio_rearm <= 1'b0;
      end
      else if (i_prio_done)
      begin
        prio_demand <= prio_write | prio_rearm;
        prio_rearm <= 1'b0;
      end
      else if (prio_write)
      begin
        prio_demand <= 1'b1;
        if (prio_demand)
          prio_rearm <= 1'b1;
      end
    end
  end

  // ****************************************
  // Missed frame address report
  // ****************************************
  always @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      drop_addr <= {ADDR_W{1'b0}};
      o_status_addr <= {ADDR_W{1'b0}};
      o_status_valid <= 1'b0;
    end
    else
    begin
      if (evt_set[`EVT_MISSED])
        drop_addr <= i_drop_addr;
      o_status_valid <= i_status_req;
      if (i_status_req)
        o_status_addr <= drop_addr;
    end
  end

  // ****************************************
  // Read data and registered outputs
  // ****************************************
  reg [15:0] mcs_value;
  reg [15:0] next_rdata;

  // Main register image
  always @*
  begin
    mcs_value = 16'h0000;
    mcs_value[`MCS_PRIORITY_TX_DEMAND] = prio_demand;
    mcs_value[`MCS_STOPPED] = stopped;
    mcs_value[`MCS_TX_DISABLE] = tx_disable;
    mcs_value[`MCS_RX_DISABLE] = rx_disable;
    mcs_value[`MCS_TX_ACTIVE] = tx_active;
    mcs_value[`MCS_RX_ACTIVE] = rx_active;
    mcs_value[`MCS_IRQ_ENABLE] = irq_enable;
    mcs_value[`MCS_IRQ_FLAG] = irq_flag;
    mcs_value[`MCS_MEM_TIMEOUT_ERR] = evt_flag[`EVT_MEM_ERR];
    mcs_value[`MCS_MISSED_FRAME] = evt_flag[`EVT_MISSED];
    mcs_value[`MCS_PRIMITIVE_IRQ] = evt_flag[`EVT_PRIM];
    mcs_value[`MCS_TX_IRQ] = evt_flag[`EVT_TX];
    mcs_value[`MCS_RX_IRQ] = evt_flag[`EVT_RX];
  end

  always @*
  begin
    if (i_port_is_select)
      next_rdata = {8'h00, select_port};
    else if (index == `IDX_MAIN_CONTROL_STATUS)
      next_rdata = mcs_value;
    else if (index <= `IDX_LAST_EXT)
      next_rdata = i_ext_rdata;
    else
      next_rdata = 16'h0000;
  end

  always @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_rdata <= 16'h0000;
      o_rvalid <= 1'b0;
      o_ext_index <= 3'h0;
      o_ext_wr <= 1'b0;
      o_ext_wdata <= 16'h0000;
      o_byte_mode <= 1'b0;
      o_high_byte <= 1'b0;
      o_stopped <= 1'b1;
      o_tx_ring_enable <= 1'b0;
      o_rx_ring_enable <= 1'b0;
      o_local_busy <= 1'b0;
      o_prio_service <= 1'b0;
      o_bus_release <= 1'b0;
      o_irq_flag_n <= 1'b1;
    end
    else
    begin
      // Host read and write paths
      o_rvalid <= access_rd;
      if (access_rd)
        o_rdata <= next_rdata;
      o_ext_index <= index;
      o_ext_wr <= data_wr & ext_hit;
      if (data_wr)
        o_ext_wdata <= i_wdata;
      o_byte_mode <= select_port[`SEL_BYTE_MODE_BIT];
      o_high_byte <= select_port[`SEL_HIGH_BYTE_BIT];
      // Phase and ring controls
      o_stopped <= stopped;
      o_tx_ring_enable <= tx_active & ~stopped;
      o_rx_ring_enable <= rx_active & ~stopped;
      o_local_busy <= rx_disable & ~stopped;
      o_prio_service <= prio_demand & tx_active;
      o_bus_release <= mem_timeout;
      o_irq_flag_n <= ~(irq_enable & irq_flag);
    end
  end

endmodule // csr_data_port_and_master_control

// file: csr_port_monitor.sv
// Concurrent checks on the pins of the CSR port block
module csr_port_monitor (
  // Clock and reset
  input wire i_ref_clk,
  input wire i_rst,
  // Host port and events
  input wire i_sel,
  input wire i_port_is_select,
  input wire i_wr,
  input wire i_rd,
  input wire i_status_req,
  input wire i_bus_master,
  input wire i_addr_driven,
  input wire i_ready,
  // Block outputs
  input wire o_rvalid,
  input wire [2:0] o_ext_index,
  input wire o_ext_wr,
  input wire o_stopped,
  input wire o_tx_ring_enable,
  input wire o_rx_ring_enable,
  input wire o_local_busy,
  input wire o_bus_release,
  input wire o_status_valid,
  input wire o_irq_flag_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);
  // ****************************************
  // Ready wait counter
  // ****************************************
  logic [8:0] wcnt;
  wire waiting = i_bus_master && i_addr_driven && !i_ready && !o_stopped;
  always @(posedge i_ref_clk or posedge i_rst)
    if (i_rst)
      wcnt <= 9'h000;
    else if (!waiting)
      wcnt <= 9'h000;
    else if (wcnt != 9'h1ff)
      wcnt <= wcnt + 9'h001;
  sequence s_long_stall;
    wcnt == 9'h100;
  endsequence
  sequence s_release_soon;
    ##[0:3] o_bus_release;
  endsequence
  a_read_answer: assert property ((i_sel && i_rd) |=> o_rvalid)
    else $error("read strobe without answer");
  a_rvalid_cause: assert property (o_rvalid |-> $past(i_sel && i_rd))
    else $error("answer without read strobe");
  a_ext_write_fwd: assert property ((i_sel && i_wr && !i_port_is_select &&
    !$past(i_sel && i_wr && i_port_is_select) &&
    o_ext_index != 3'h0 && o_ext_index <= 3'h5) |=> o_ext_wr)
    else $error("data port write not forwarded");
  a_status_echo: assert property (i_status_req |=> o_status_valid)
    else $error("status request not answered");
  a_release_pulse: assert property (o_bus_release |=> !o_bus_release)
    else $error("bus release longer than a cycle");
  a_timeout_fires: assert property (s_long_stall |-> s_release_soon)
    else $error("no release after long ready wait");
  a_no_early_fire: assert property ($rose(o_bus_release) |-> $past(wcnt, 2) >= 9'h0ff)
    else $error("release before wait limit");
  a_drop_rings: assert property ($rose(o_bus_release) |-> ##2 !o_tx_ring_enable
    && !o_rx_ring_enable)
    else $error("rings still on after memory timeout");
  a_stop_quiet_irq: assert property (o_stopped [*3] |-> o_irq_flag_n)
    else $error("interrupt pin low while stopped");
  a_stop_rings_off: assert property (o_stopped [*2] |-> !o_tx_ring_enable &&
    !o_rx_ring_enable && !o_local_busy)
    else $error("activity while stopped");
endmodule // csr_port_monitor

bind csr_data_port_and_master_control csr_port_monitor mon_u (
  .i_ref_clk(i_ref_clk),
  .i_rst(i_rst),
  .i_sel(i_sel),
  .i_port_is_select(i_port_is_select),
  .i_wr(i_wr),
  .i_rd(i_rd),
  .i_status_req(i_status_req),
  .i_bus_master(i_bus_master),
  .i_addr_driven(i_addr_driven),
  .i_ready(i_ready),
  .o_rvalid(o_rvalid),
  .o_ext_index(o_ext_index),
  .o_ext_wr(o_ext_wr),
  .o_stopped(o_stopped),
  .o_tx_ring_enable(o_tx_ring_enable),
  .o_rx_ring_enable(o_rx_ring_enable),
  .o_local_busy(o_local_busy),
  .o_bus_release(o_bus_release),
  .o_status_valid(o_status_valid),
  .o_irq_flag_n(o_irq_flag_n)
);

// file: host_bus_model.sv
// Host processor model on the register select and data ports
module host_bus_model (
  // Clock and answer
  input wire logic i_ref_clk,
  input wire logic [15:0] i_rdata,
  input wire logic i_rvalid,
  // Bus strobes and data
  output logic o_sel,
  output logic o_port_is_select,
  output logic o_wr,
  output logic o_rd,
  output logic [15:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    o_sel = 1'b0;
    o_port_is_select = 1'b0;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 16'hffff;
  end
  task write_port(input logic is_sel, input logic [15:0] d);
    @(posedge i_ref_clk);
    #1 o_sel = 1'b1;
    o_port_is_select = is_sel;
    o_wr = 1'b1;
    o_wdata = d;
    @(posedge i_ref_clk);
    #1 o_sel = 1'b0;
    o_wr = 1'b0;
    o_wdata = ~d;
  endtask
  task read_port(output logic [15:0] d);
    @(posedge i_ref_clk);
    #1 o_sel = 1'b1;
    o_port_is_select = 1'b0;
    o_rd = 1'b1;
    @(posedge i_ref_clk);
    #1 o_sel = 1'b0;
    o_rd = 1'b0;
    d = (i_rvalid === 1'b1) ? i_rdata : 16'hdead;
  endtask
endmodule // host_bus_model

// file: csr_data_port_and_master_control_tb.sv
// Self-checking bench for the CSR port block
module csr_data_port_and_master_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] ev = 8'h00;
  logic i_bus_master = 1'b0;
  logic i_addr_driven = 1'b0;
  logic i_ready = 1'b1;
  logic [23:0] i_drop_addr = 24'h000000;
  logic [15:0] i_ext_rdata = 16'h5a5a;
  logic i_tx_frame_busy = 1'b0;
  logic i_rx_frame_busy = 1'b0;
  wire logic i_prim_update = ev[6];
  wire logic i_rx_ring_update = ev[7];
  wire logic i_start_prim = ev[0];
  wire logic i_stop_prim = ev[1];
  wire logic i_prio_done = ev[2];
  wire logic i_tx_ring_update = ev[3];
  wire logic i_rx_drop = ev[4];
  wire logic i_status_req = ev[5];
  logic i_sel, i_port_is_select, i_wr, i_rd;
  logic [15:0] i_wdata, o_rdata, o_ext_wdata, v;
  logic o_rvalid, o_ext_wr, o_byte_mode, o_high_byte, o_stopped, o_tx_ring_enable;
  logic o_rx_ring_enable, o_local_busy, o_prio_service, o_bus_release, o_status_valid, o_irq_flag_n;
  logic [2:0] o_ext_index;
  logic [23:0] o_status_addr;
  int num_errors = 0;
  int compares = 0;
  csr_data_port_and_master_control dut_u (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_sel(i_sel),
    .i_port_is_select(i_port_is_select),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .i_wdata(i_wdata),
    .o_rdata(o_rdata),
    .o_rvalid(o_rvalid),
    .o_ext_index(o_ext_index),
    .o_ext_wr(o_ext_wr),
    .o_ext_wdata(o_ext_wdata),
    .i_ext_rdata(i_ext_rdata),
    .o_byte_mode(o_byte_mode),
    .o_high_byte(o_high_byte),
    .i_start_prim(i_start_prim),
    .i_stop_prim(i_stop_prim),
    .i_tx_frame_busy(i_tx_frame_busy),
    .i_rx_frame_busy(i_rx_frame_busy),
    .i_prio_done(i_prio_done),
    .i_rx_ring_update(i_rx_ring_update),
    .i_tx_ring_update(i_tx_ring_update),
    .i_prim_update(i_prim_update),
    .i_rx_drop(i_rx_drop),
    .i_drop_addr(i_drop_addr),
    .i_status_req(i_status_req),
    .i_bus_master(i_bus_master),
    .i_addr_driven(i_addr_driven),
    .i_ready(i_ready),
    .o_stopped(o_stopped),
    .o_tx_ring_enable(o_tx_ring_enable),
    .o_rx_ring_enable(o_rx_ring_enable),
    .o_local_busy(o_local_busy),
    .o_prio_service(o_prio_service),
    .o_bus_release(o_bus_release),
    .o_status_addr(o_status_addr),
    .o_status_valid(o_status_valid),
    .o_irq_flag_n(o_irq_flag_n)
  );
  host_bus_model host_u (
    .i_ref_clk(i_ref_clk),
    .i_rdata(o_rdata),
    .i_rvalid(o_rvalid),
    .o_sel(i_sel),
    .o_port_is_select(i_port_is_select),
    .o_wr(i_wr),
    .o_rd(i_rd),
    .o_wdata(i_wdata)
  );
  initial
  begin
    forever #20 i_ref_clk = ~i_ref_clk;
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task chk(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task rdc(input logic [15:0] exp);
    host_u.read_port(v);
    chk(24'(v), 24'(exp));
  endtask
  task wrd(input logic [15:0] d);
    host_u.write_port(1'b0, d);
  endtask
  task pulse(input int b);
    @(posedge i_ref_clk);
    #1 ev[b] = 1'b1;
    @(posedge i_ref_clk);
    #1 ev[b] = 1'b0;
  endtask
  task stop_test();
    if (num_errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task t_stopped();
    rdc(16'h4000);
    wrd(16'h0200);
    rdc(16'h4000);
    chk(24'(o_irq_flag_n), 24'h1);
  endtask
  task t_start();
    pulse(0);
    rdc(16'h0c00);
    chk(24'({o_tx_ring_enable, o_rx_ring_enable, o_stopped}), 24'h6);
  endtask
  task t_disable();
    i_tx_frame_busy = 1'b1;
    i_rx_frame_busy = 1'b1;
    wrd(16'h3c00);
    rdc(16'h3c00);
    i_tx_frame_busy = 1'b0;
    i_rx_frame_busy = 1'b0;
    rdc(16'h3000);
    chk(24'({o_tx_ring_enable, o_rx_ring_enable, o_local_busy}), 24'h1);
    wrd(16'h0000);
    rdc(16'h0c00);
  endtask
  task t_irq();
    wrd(16'h0200);
    pulse(3);
    pulse(6);
    pulse(7);
    rdc(16'h0f0e);
    @(posedge i_ref_clk);
    #1 chk(24'(o_irq_flag_n), 24'h0);
    wrd(16'h020e);
    rdc(16'h0e00);
    wrd(16'h0000);
    rdc(16'h0c00);
  endtask
  task t_drop();
    i_drop_addr = 24'h00a5c3;
    pulse(4);
    rdc(16'h0d40);
    pulse(5);
    chk(o_status_addr, 24'h00a5c3);
    chk(24'(o_status_valid), 24'h1);
    wrd(16'h0040);
    rdc(16'h0c00);
  endtask
  task t_prio();
    wrd(16'h8000);
    rdc(16'h8c00);
    chk(24'(o_prio_service), 24'h1);
    wrd(16'h8000);
    pulse(2);
    rdc(16'h8c00);
    pulse(2);
    rdc(16'h0c00);
  endtask
  task t_ext();
    host_u.write_port(1'b1, 16'h0004);
    wrd(16'habcd);
    chk({o_ext_wr, o_ext_index, 4'h0, o_ext_wdata}, 24'ha0abcd);
    rdc(16'h5a5a);
    host_u.write_port(1'b1, 16'h000c);
    rdc(16'h0000);
    host_u.write_port(1'b1, 16'h0081);
    @(posedge i_ref_clk);
    #1 chk(24'({o_byte_mode, o_high_byte}), 24'h3);
    host_u.write_port(1'b1, 16'h0000);
  endtask
  task t_timeout();
    i_bus_master = 1'b1;
    i_addr_driven = 1'b1;
    i_ready = 1'b0;
    repeat (257) @(posedge i_ref_clk);
    #1 chk(24'(o_bus_release), 24'h1);
    i_ready = 1'b1;
    rdc(16'h0180);
    chk(24'({o_tx_ring_enable, o_rx_ring_enable}), 24'h0);
    wrd(16'h0080);
    rdc(16'h0000);
  endtask
  task t_stop();
    pulse(0);
    wrd(16'h0200);
    pulse(3);
    pulse(1);
    rdc(16'h4000);
    chk(24'(o_irq_flag_n), 24'h1);
    pulse(6);
    rdc(16'h4108);
    chk(24'(o_irq_flag_n), 24'h1);
    wrd(16'h0008);
    rdc(16'h4000);
  endtask
  initial
  begin
    repeat (6) @(posedge i_ref_clk);
    #1 i_rst = 1'b0;
    t_stopped();
    t_start();
    t_disable();
    t_irq();
    t_drop();
    t_prio();
    t_ext();
    t_timeout();
    t_stop();
    stop_test();
  end
endmodule // csr_data_port_and_master_control_tb
